// [logic/spsa_pkg.sv]
// constants and types shared by the serial port block
package spsa_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_BUF        = 8'h04;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // serial_control field positions
  localparam int          CTL_TXF         = 0;
  localparam int          CTL_RXF         = 1;
  localparam int          CTL_RXB         = 2;
  localparam int          CTL_REN         = 4;
  localparam int          CTL_SPD         = 5;
  localparam int          CTL_MSL         = 6;
  localparam int          CTL_MSH         = 7;
  localparam int          CTL_DBL         = 8;
  localparam logic [1:0]  MODE_SYNC       = 2'h0;
  localparam logic [1:0]  MODE_ASYNC      = 2'h1;
  // machine cycle: 12 clocks, state six phase two is the last
  localparam logic [3:0]  PH_LAST         = 4'hB;
  localparam logic [3:0]  PH_SIX_TWO      = 4'hB;
  // synchronous mode timing in clock periods
  localparam logic [3:0]  M0_SETUP_FAST   = 4'h1;
  localparam logic [3:0]  M0_LOW_FAST     = 4'h2;
  localparam logic [3:0]  M0_PER_FAST     = 4'h4;
  localparam logic [3:0]  M0_SETUP_SLOW   = 4'h3;
  localparam logic [3:0]  M0_LOW_SLOW     = 4'h6;
  localparam logic [3:0]  M0_PER_SLOW     = 4'hC;
  localparam logic [3:0]  FRAME_BITS      = 4'h8;
  // asynchronous mode
  localparam logic [3:0]  DIV16_TOP       = 4'hF;
  localparam logic [3:0]  TX_LAST_STEP    = 4'h9;
  localparam logic [3:0]  RX_LAST_BIT     = 4'h9;
  localparam logic [3:0]  VOTE_A          = 4'h7;
  localparam logic [3:0]  VOTE_B          = 4'h8;
  localparam logic [3:0]  VOTE_C          = 4'h9;
  localparam logic        LINE_IDLE       = 1'b1;
  typedef enum {M0_IDLE, M0_TX, M0_RX, M0_DONE} spsa_m0_t;
endpackage : spsa_pkg

// [logic/spsa_top.sv]
// serial port with synchronous shift and 10-bit asynchronous modes
// How it works
// - buffer write loads transmit, read gives receive
// - sync mode: data on rxd, clock on txd
// - sync frame eight bits, lsb first
// - speed bit picks shift rate, zero is /12
// - fast: data 1 before fall, low 2
// - slow: data 3 before fall, low 6
// - sync: buffer write shifts out eight bits
// - sync transmit flag set at state_six_phase_two
// - sync receive starts when enabled, flag clear
// - sync receive flag set, reception then halts
// - async frame: start 0, eight data, stop 1
// - async rate is baud tick /16 or /32
// - async transmit steps on divide-16 rollovers
// - transmit flag at tenth rollover after write
// - receiver samples at sixteen times bit rate
// - falling edge resets receive divide-16 counter
// - bit is majority of samples 7,8,9
// - nonzero start bit aborts the frame
// - store stop, data, flag only when allowed
// - after stop middle, hunt for falling edge
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module spsa_top (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic [spsa_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                       AWVALID,
  output logic                            AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic [3:0]                 WSTRB,
  input  wire logic                       WVALID,
  output logic                            WREADY,
  output logic [1:0]                      BRESP,
  output logic                            BVALID,
  input  wire logic                       BREADY,
  input  wire logic [spsa_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                       ARVALID,
  output logic                            ARREADY,
  output logic [31:0]                     RDATA,
  output logic [1:0]                      RRESP,
  output logic                            RVALID,
  input  wire logic                       RREADY,
  input  wire logic                       BAUD_TICK,
  input  wire logic                       RXD_I,
  output logic                            RXD_O,
  output logic                            RXD_OE,
  output logic                            TXD_O
);
  import spsa_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

  logic              aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r, rdata_r, ctrl_val;
  logic [3:0]        wstrb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic              wr_go, wr_ctrl, wr_buf;
  logic              ren_r, spd_r, msl_r, msh_r, dbl_r;
  logic              txf_r, rxf_r, rxb_r;
  logic [7:0]        rx_buf_r;
  logic              mode_sync, mode_async;
  logic              rxd_s1_r, rxd_s2_r;
  logic [3:0]        ph_r;
  logic              ph_six_two;
  spsa_m0_t          m0_st_r;
  logic [3:0]        m0_cnt_r, m0_bit_r, m0_per, m0_set, m0_low;
  logic [7:0]        m0_sh_r;
  logic              m0_clk_r, m0_dat_r, m0_oe_r, m0_tx_r;
  logic              m0_last, m0_rise, m0_done_ev;
  logic              half_r, s16_tick, roll;
  logic [3:0]        tc_r;
  logic              t1_act_r, t1_due_r, t1_line_r, t1_done_ev;
  logic [3:0]        t1_step_r;
  logic [7:0]        t1_sh_r;
  logic              r1_busy_r, r1_prev_r, v1_r, v2_r, vote, fall;
  logic [3:0]        rc_r, rb_r;
  logic [7:0]        r1_sh_r;
  logic              r1_store_ev, txf_set, rxf_set;

  // bus slave: address and data are caught in either order
  assign AWREADY = !aw_hold_r;
  assign WREADY  = !w_hold_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign ARREADY = !rvalid_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;
  assign wr_go   = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_ctrl = wr_go && hit(awaddr_r, ADDR_CTRL);
  assign wr_buf  = wr_go && hit(awaddr_r, ADDR_BUF) && wstrb_r[0];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (AWVALID && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= AWADDR;
      end
      if (WVALID && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (hit(awaddr_r, ADDR_CTRL) || hit(awaddr_r, ADDR_BUF))
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    ctrl_val          = '0;
    ctrl_val[CTL_TXF] = txf_r;
    ctrl_val[CTL_RXF] = rxf_r;
    ctrl_val[CTL_RXB] = rxb_r;
    ctrl_val[CTL_REN] = ren_r;
    ctrl_val[CTL_SPD] = spd_r;
    ctrl_val[CTL_MSL] = msl_r;
    ctrl_val[CTL_MSH] = msh_r;
    ctrl_val[CTL_DBL] = dbl_r;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ARVALID && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      if (hit(ARADDR, ADDR_CTRL)) begin
        rdata_r <= ctrl_val;
      end else if (hit(ARADDR, ADDR_BUF)) begin
        rdata_r <= {24'h000000, rx_buf_r};
      end else begin
        rdata_r <= '0;
        rresp_r <= RESP_SLVERR;
      end
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // configuration bits of serial_control
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ren_r <= 1'b0;
      spd_r <= 1'b0;
      msl_r <= 1'b0;
      msh_r <= 1'b0;
      dbl_r <= 1'b0;
    end else begin
      if (wr_ctrl && wstrb_r[0]) begin
        ren_r <= wdata_r[CTL_REN];
        spd_r <= wdata_r[CTL_SPD];
        msl_r <= wdata_r[CTL_MSL];
        msh_r <= wdata_r[CTL_MSH];
      end
      if (wr_ctrl && wstrb_r[1]) begin
        dbl_r <= wdata_r[CTL_DBL];
      end
    end
  end

  assign mode_sync  = {msh_r, msl_r} == MODE_SYNC;
  assign mode_async = {msh_r, msl_r} == MODE_ASYNC;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxd_s1_r <= LINE_IDLE;
      rxd_s2_r <= LINE_IDLE;
    end else begin
      rxd_s1_r <= RXD_I;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  // machine cycle phase counter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_r <= '0;
    end else begin
      ph_r <= (ph_r == PH_LAST) ? 4'h0 : ph_r + 4'h1;
    end
  end
  assign ph_six_two = ph_r == PH_SIX_TWO;

  // synchronous shift mode
  assign m0_per  = spd_r ? M0_PER_FAST   : M0_PER_SLOW;
  assign m0_set  = spd_r ? M0_SETUP_FAST : M0_SETUP_SLOW;
  assign m0_low  = spd_r ? M0_LOW_FAST   : M0_LOW_SLOW;
  assign m0_last = m0_cnt_r == m0_per - 4'h1;
  assign m0_rise = m0_cnt_r == m0_set + m0_low;
  assign m0_done_ev = mode_sync && (m0_st_r == M0_DONE) && ph_six_two;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      m0_st_r  <= M0_IDLE;
      m0_cnt_r <= '0;
      m0_bit_r <= '0;
      m0_sh_r  <= '0;
      m0_clk_r <= 1'b1;
      m0_dat_r <= 1'b1;
      m0_oe_r  <= 1'b0;
      m0_tx_r  <= 1'b0;
    end else if (!mode_sync) begin
      m0_st_r  <= M0_IDLE;
      m0_clk_r <= 1'b1;
      m0_oe_r  <= 1'b0;
    end else begin
      case (m0_st_r)
        M0_IDLE: begin
          m0_clk_r <= 1'b1;
          m0_cnt_r <= m0_per - 4'h1;
          m0_bit_r <= '0;
          if (wr_buf) begin
            m0_st_r <= M0_TX;
            m0_sh_r <= wdata_r[7:0];
            m0_oe_r <= 1'b1;
            m0_tx_r <= 1'b1;
          end else if (ren_r && !rxf_r) begin
            m0_st_r <= M0_RX;
            m0_tx_r <= 1'b0;
          end
        end
        M0_TX, M0_RX: begin
          m0_cnt_r <= m0_last ? 4'h0 : m0_cnt_r + 4'h1;
          // clock low from setup to setup+low-1 of each bit period
          m0_clk_r <= !((m0_cnt_r >= m0_set - 4'h1) &&
                        (m0_cnt_r <= m0_set + m0_low - 4'h2));
          if (m0_st_r == M0_RX && m0_rise) begin
            m0_sh_r <= {rxd_s2_r, m0_sh_r[7:1]};
          end
          if (m0_last) begin
            if (m0_bit_r == FRAME_BITS) begin
              m0_st_r  <= M0_DONE;
              m0_clk_r <= 1'b1;
            end else begin
              m0_bit_r <= m0_bit_r + 4'h1;
              if (m0_st_r == M0_TX) begin
                m0_dat_r <= m0_sh_r[0];
                m0_sh_r  <= {1'b0, m0_sh_r[7:1]};
              end
            end
          end
        end
        M0_DONE: begin
          m0_clk_r <= 1'b1;
          if (ph_six_two) begin
            m0_st_r <= M0_IDLE;
            m0_oe_r <= 1'b0;
          end
        end
        default: m0_st_r <= M0_IDLE;
      endcase
    end
  end

  // baud tick divided by 2 unless doubled, then by 16
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      half_r <= 1'b0;
      tc_r   <= '0;
    end else begin
      if (BAUD_TICK) begin
        half_r <= !half_r;
      end
      if (s16_tick) begin
        tc_r <= tc_r + 4'h1;
      end
    end
  end
  assign s16_tick = BAUD_TICK && (dbl_r || half_r);
  assign roll     = s16_tick && (tc_r == DIV16_TOP);

  // asynchronous transmitter, stepped by rollovers at state_six_phase_two
  assign t1_done_ev = mode_async && t1_act_r && t1_due_r && ph_six_two &&
                      (t1_step_r == TX_LAST_STEP);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      t1_act_r  <= 1'b0;
      t1_due_r  <= 1'b0;
      t1_step_r <= '0;
      t1_sh_r   <= '0;
      t1_line_r <= LINE_IDLE;
    end else if (!mode_async) begin
      t1_act_r  <= 1'b0;
      t1_due_r  <= 1'b0;
      t1_line_r <= LINE_IDLE;
    end else if (wr_buf) begin
      t1_act_r  <= 1'b1;
      t1_due_r  <= 1'b0;
      t1_step_r <= '0;
      t1_sh_r   <= wdata_r[7:0];
    end else if (t1_act_r) begin
      if (t1_due_r && ph_six_two) begin
        t1_due_r  <= 1'b0;
        t1_step_r <= t1_step_r + 4'h1;
        if (t1_step_r == 4'h0) begin
          t1_line_r <= 1'b0;
        end else if (t1_step_r == TX_LAST_STEP) begin
          t1_line_r <= 1'b1;
          t1_act_r  <= 1'b0;
        end else begin
          t1_line_r <= t1_sh_r[0];
          t1_sh_r   <= {1'b0, t1_sh_r[7:1]};
        end
      end
      if (roll) begin
        t1_due_r <= 1'b1;
      end
    end
  end

  // asynchronous receiver
  assign fall = s16_tick && r1_prev_r && !rxd_s2_r;
  assign vote = maj3(v1_r, v2_r, rxd_s2_r);
  assign r1_store_ev = mode_async && ren_r && r1_busy_r && s16_tick &&
                       (rc_r == VOTE_C) && (rb_r == RX_LAST_BIT) &&
                       !rxf_r && (!spd_r || vote);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r1_prev_r <= LINE_IDLE;
    end else if (s16_tick) begin
      r1_prev_r <= rxd_s2_r;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r1_busy_r <= 1'b0;
      rc_r      <= '0;
      rb_r      <= '0;
      v1_r      <= 1'b1;
      v2_r      <= 1'b1;
      r1_sh_r   <= '0;
    end else if (!mode_async || !ren_r) begin
      r1_busy_r <= 1'b0;
    end else if (!r1_busy_r) begin
      if (fall) begin
        r1_busy_r <= 1'b1;
        rc_r      <= '0;
        rb_r      <= '0;
      end
    end else if (s16_tick) begin
      rc_r <= rc_r + 4'h1;
      if (rc_r == VOTE_A) begin
        v1_r <= rxd_s2_r;
      end
      if (rc_r == VOTE_B) begin
        v2_r <= rxd_s2_r;
      end
      if (rc_r == VOTE_C) begin
        rb_r <= rb_r + 4'h1;
        if (rb_r == 4'h0 && vote) begin
          r1_busy_r <= 1'b0;
        end else if (rb_r == RX_LAST_BIT) begin
          r1_busy_r <= 1'b0;
        end else if (rb_r != 4'h0) begin
          r1_sh_r <= {vote, r1_sh_r[7:1]};
        end
      end
    end
  end

  // done flags: hardware sets, only software clears, a set wins
  assign txf_set = (m0_done_ev && m0_tx_r) || t1_done_ev;
  assign rxf_set = (m0_done_ev && !m0_tx_r) || r1_store_ev;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txf_r    <= 1'b0;
      rxf_r    <= 1'b0;
      rxb_r    <= 1'b0;
      rx_buf_r <= '0;
    end else begin
      if (txf_set) begin
        txf_r <= 1'b1;
      end else if (wr_ctrl && wstrb_r[0]) begin
        txf_r <= wdata_r[CTL_TXF];
      end
      if (rxf_set) begin
        rxf_r <= 1'b1;
      end else if (wr_ctrl && wstrb_r[0]) begin
        rxf_r <= wdata_r[CTL_RXF];
      end
      if (r1_store_ev) begin
        rxb_r    <= vote;
        rx_buf_r <= r1_sh_r;
      end else if (m0_done_ev && !m0_tx_r) begin
        rx_buf_r <= m0_sh_r;
      end else if (wr_ctrl && wstrb_r[0]) begin
        rxb_r <= wdata_r[CTL_RXB];
      end
    end
  end

  assign TXD_O  = mode_sync ? m0_clk_r : t1_line_r;
  assign RXD_O  = m0_dat_r;
  assign RXD_OE = m0_oe_r && m0_tx_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_buf_read_rx: assert property (
    (ARVALID && ARREADY && hit(ARADDR, ADDR_BUF))
      |=> RDATA[7:0] == $past(rx_buf_r))
    else $error("buffer read does not return receive data");
  a_sync_tx_drive: assert property (
    (mode_sync && m0_st_r == M0_TX) |-> RXD_OE)
    else $error("data pin not driven during sync transmit");
  a_fast_low_two: assert property (
    ($fell(TXD_O) && mode_sync && spd_r && $stable(spd_r))
      |-> !TXD_O [*2] ##1 TXD_O)
    else $error("fast shift clock low time is not two");
  a_slow_low_six: assert property (
    ($fell(TXD_O) && mode_sync && !spd_r && $stable(spd_r))
      |-> !TXD_O [*6] ##1 TXD_O)
    else $error("slow shift clock low time is not six");
  a_flag_at_six_two: assert property (
    (!txf_r ##1 (txf_r && !$past(wr_ctrl && wstrb_r[0])))
      |-> $past(ph_r) == PH_SIX_TWO)
    else $error("transmit flag set outside state six phase two");
  a_rx_halt_flag: assert property (
    (mode_sync && m0_st_r == M0_IDLE && rxf_r && !wr_buf)
      |=> m0_st_r == M0_IDLE)
    else $error("sync reception started with receive flag set");
  a_start_bit_low: assert property (
    (mode_async && t1_act_r && t1_due_r && ph_six_two && t1_step_r == 4'h0
      && !wr_buf) |=> !TXD_O)
    else $error("start bit not low");
  a_bad_start: assert property (
    (mode_async && ren_r && r1_busy_r && s16_tick && rc_r == VOTE_C
      && rb_r == 4'h0 && vote) |=> !r1_busy_r)
    else $error("invalid start bit not aborted");
  a_store_cond: assert property (
    r1_store_ev |=> rxf_r && rx_buf_r == $past(r1_sh_r))
    else $error("frame store did not load buffer and flag");
  a_flag_sticky: assert property (
    (txf_r && !(wr_ctrl && wstrb_r[0])) |=> txf_r)
    else $error("transmit flag cleared without software");
endmodule : spsa_top

// [dv/spsa_far.sv]
// far-side model: external shift register and asynchronous sender
`timescale 1ns/1ps
module spsa_far #(
  parameter int BIT_CLK = 64
) (
  input  wire logic       CLK,
  input  wire logic       TXD_O,
  input  wire logic       RXD_O,
  input  wire logic       RXD_OE,
  output logic            line_o,
  output logic [7:0]      got
);
  logic [7:0] sr;
  int         cnt;
  logic       sync_on;
  initial begin
    line_o = 1'b1;
    got = 8'h00;
    cnt = 8;
    sync_on = 1'b0;
  end
  task automatic load(input logic [7:0] d);
    sr = d;
    cnt = 0;
    sync_on = 1'b1;
  endtask : load
  // new bit only on the falling shift clock
  always @(negedge TXD_O) begin
    if (!RXD_OE && cnt < 8) begin
      line_o <= sr[cnt];
      cnt <= cnt + 1;
    end
  end
  // capture transmitted bits; release the line after the last one
  always @(posedge TXD_O) begin
    if (RXD_OE) got <= {RXD_O, got[7:1]};
    if (sync_on && cnt == 8 && !RXD_OE) begin
      sync_on <= 1'b0;
      line_o <= #400 1'b1;
    end
  end
  task automatic send(input logic [7:0] d, input logic stop,
                      input logic bad);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    if (bad) begin
      line_o <= 1'b0;
      repeat (BIT_CLK / 4) @(posedge CLK);
      line_o <= 1'b1;
      repeat (BIT_CLK) @(posedge CLK);
    end
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT_CLK) @(posedge CLK);
    end
    line_o <= 1'b1;
    repeat (BIT_CLK) @(posedge CLK);
  endtask : send
endmodule : spsa_far

// [dv/serial_port_sync_async_tb.sv]
// self-checking bench for the serial port block
`timescale 1ns/1ps
module serial_port_sync_async_tb;
  import spsa_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [1:0]  br;
    logic [31:0] rd;
    logic [1:0]  rs;
  } spsa_row_t;
  logic        CLK, RST_N, BAUD_TICK;
  logic [7:0]  AWADDR, ARADDR, far_got;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic [31:0] WDATA, RDATA, rv;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rr;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic        RXD_I, RXD_O, RXD_OE, TXD_O, far_line, d_q, t_q;
  int          errors, checks_done, tick_c, falls;
  int          su_c, lo_c, ff_c, last_su, last_lo, last_per;
  spsa_row_t   rows [5] = '{
    '{ADDR_CTRL, 32'h1F8, RESP_OKAY, 32'h1F0, RESP_OKAY},
    '{ADDR_CTRL, 32'hC3, RESP_OKAY, 32'hC3, RESP_OKAY},
    '{ADDR_CTRL, 32'h0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{8'h08, 32'hFF, RESP_SLVERR, 32'h0, RESP_SLVERR},
    '{8'hFC, 32'h1, RESP_SLVERR, 32'h0, RESP_SLVERR}};
  assign RXD_I = RXD_OE ? RXD_O : far_line;
  spsa_top dut_u (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .BAUD_TICK(BAUD_TICK), .RXD_I(RXD_I),
    .RXD_O(RXD_O), .RXD_OE(RXD_OE), .TXD_O(TXD_O));
  spsa_far far_u (.CLK(CLK), .TXD_O(TXD_O), .RXD_O(RXD_O),
    .RXD_OE(RXD_OE), .line_o(far_line), .got(far_got));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // baud tick every fourth clock
  always @(posedge CLK) begin
    tick_c <= (tick_c + 1) % 4;
    BAUD_TICK <= (tick_c == 3);
  end
  // shift clock timing: data setup, low time, fall-to-fall period
  always @(posedge CLK) begin
    d_q <= RXD_O;
    t_q <= TXD_O;
    su_c <= (RXD_O !== d_q) ? 0 : su_c + 1;
    lo_c <= TXD_O ? 0 : lo_c + 1;
    ff_c <= (t_q && !TXD_O) ? 1 : ff_c + 1;
    if (t_q && !TXD_O) begin
      last_su <= su_c + 1;
      last_per <= ff_c;
      falls <= falls + 1;
    end
    if (!t_q && TXD_O) last_lo <= lo_c;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic tmo(input string n);
    errors++;
    $display("[FAIL] %s exp done got timeout", n);
    print_verdict;
  endtask : tmo
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w, b;
    int   n;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b) begin
      @(negedge CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      r = BRESP;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (++n > 200) tmo("write");
    end
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar, v;
    int   n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    v = 1'b0;
    n = 0;
    while (!v) begin
      @(negedge CLK);
      ar = ARVALID && ARREADY;
      v = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
      if (++n > 200) tmo("read");
    end
    RREADY <= 1'b0;
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    rd(a, rv, rr);
    chk(n, e, rv);
  endtask : rc
  task automatic wait_ctl(input int b);
    int n;
    n = 0;
    rv = '0;
    while (rv[b] !== 1'b1) begin
      rd(ADDR_CTRL, rv, rr);
      if (++n > 600) tmo("flag");
    end
  endtask : wait_ctl
  task automatic sync_tx(input logic [31:0] c, input int lo, su, per);
    wr(ADDR_CTRL, c, rr);
    falls = 0;
    wr(ADDR_BUF, 32'h55, rr);
    wait_ctl(CTL_TXF);
    chk("falls", 32'd8, 32'(falls));
    chk("tx byte", 32'h55, {24'h0, far_got});
    chk("low", 32'(lo), 32'(last_lo));
    chk("setup", 32'(su), 32'(last_su));
    chk("period", 32'(per), 32'(last_per));
    chk("oe off", 32'h0, {31'h0, RXD_OE});
  endtask : sync_tx
  task automatic async_tx(input logic [31:0] c, input int bc);
    logic [9:0] fr;
    int         n;
    wr(ADDR_CTRL, c, rr);
    wr(ADDR_BUF, 32'h96, rr);
    n = 0;
    while (TXD_O !== 1'b0) begin
      @(negedge CLK);
      if (++n > 3000) tmo("start");
    end
    repeat (bc / 2) @(negedge CLK);
    for (int i = 0; i < 10; i++) begin
      fr[i] = TXD_O;
      if (i < 9) repeat (bc) @(negedge CLK);
    end
    chk("frame", {22'h0, 1'b1, 8'h96, 1'b0}, {22'h0, fr});
    rd(ADDR_CTRL, rv, rr);
    chk("tx done", 32'h1, {31'h0, rv[CTL_TXF]});
  endtask : async_tx
  initial begin
    {RST_N, BAUD_TICK, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, tick_c, falls} = '0;
    {su_c, lo_c, ff_c, last_su, last_lo, last_per} = '0;
    {d_q, t_q} = 2'b11;
    WSTRB = 4'hF;
    errors = 0;
    checks_done = 0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    chk("txd idle", 32'h1, {31'h0, TXD_O});
    chk("oe idle", 32'h0, {31'h0, RXD_OE});
    rc("ctl reset", ADDR_CTRL, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, rr);
      chk("bresp", 32'(rows[i].br), 32'(rr));
      rd(rows[i].a, rv, rr);
      chk("rdata", rows[i].rd, rv);
      chk("rresp", 32'(rows[i].rs), 32'(rr));
    end
    sync_tx(32'h20, 2, 1, 4);
    sync_tx(32'h0, 6, 3, 12);
    far_u.load(8'h3C);
    falls = 0;
    wr(ADDR_CTRL, 32'h30, rr);
    wait_ctl(CTL_RXF);
    rc("sync rx", ADDR_BUF, 32'h3C);
    chk("rx clocks", 32'd8, 32'(falls));
    falls = 0;
    repeat (60) @(posedge CLK);
    chk("halt", 32'h0, 32'(falls));
    wr(ADDR_CTRL, 32'h0, rr);
    async_tx(32'h140, 64);
    async_tx(32'h040, 128);
    wr(ADDR_CTRL, 32'h150, rr);
    far_u.send(8'hC3, 1'b1, 1'b0);
    rc("rx ctl", ADDR_CTRL, 32'h156);
    rc("rx buf", ADDR_BUF, 32'hC3);
    far_u.send(8'h11, 1'b1, 1'b0);
    rc("kept buf", ADDR_BUF, 32'hC3);
    wr(ADDR_CTRL, 32'h150, rr);
    far_u.send(8'h5A, 1'b0, 1'b1);
    rc("bad start", ADDR_CTRL, 32'h152);
    rc("rx buf 2", ADDR_BUF, 32'h5A);
    wr(ADDR_CTRL, 32'h170, rr);
    far_u.send(8'h77, 1'b0, 1'b0);
    rc("dropped", ADDR_CTRL, 32'h170);
    print_verdict;
  end
endmodule : serial_port_sync_async_tb
